// ==== rtl/imp_pkg.sv ====
package imp_pkg;

    // Clock source select encodings.
    localparam logic [1:0] IMP_SEL_INTERNAL  = 2'h3;
    localparam logic [1:0] IMP_SEL_SECONDARY = 2'h1;
    localparam logic [1:0] IMP_SEL_PRIMARY   = 2'h2;

    // Register offsets of the plain register port.
    localparam logic [3:0] IMP_OFS_CTRL   = 4'h0;
    localparam logic [3:0] IMP_OFS_STATUS = 4'h1;
    localparam logic [3:0] IMP_OFS_IRQCTL = 4'h2;
    localparam logic [3:0] IMP_OFS_PIE    = 4'h3;

    // Control and interrupt control register fields.
    localparam int IMP_CTRL_IDLE_BIT = 7;
    localparam int IMP_CTRL_SEL_LSB  = 0;
    localparam int IMP_CTRL_T1EN_BIT = 2;
    localparam int IMP_CTRL_WDTE_BIT = 3;
    localparam int IMP_CTRL_FSCM_BIT = 4;
    localparam int IMP_IRQ_GIE_BIT   = 7;

    // Reset values.
    localparam logic [1:0] IMP_SEL_RST  = 2'h2;
    localparam logic [7:0] IMP_IRQ_RST  = 8'h00;
    localparam logic [7:0] IMP_PIE_RST  = 8'h00;

    // Wake delay as printed, in ns, and derived cycle count at 200 MHz.
    localparam int IMP_CLK_PERIOD_PS = 5000;
    localparam int IMP_WAKE_DELAY_NS = 200;
    localparam int IMP_WAKE_CYCLES   = (IMP_WAKE_DELAY_NS * 1000 + IMP_CLK_PERIOD_PS - 1)
                                       / IMP_CLK_PERIOD_PS;

    // Watchdog defaults.
    localparam int IMP_WDT_WIDTH = 16;

    typedef enum {
        IMP_RUN,
        IMP_IDLE,
        IMP_SLEEP,
        IMP_WAIT_OSC,
        IMP_WAKE
    } imp_mode_t;

    typedef struct packed {
        logic       cpu_clk_en;
        logic       periph_clk_en;
        logic       pri_osc_en;
        logic       sec_osc_run;
        logic       int_osc_run;
        logic [1:0] cpu_src;
    } imp_clk_t;

endpackage : imp_pkg

// ==== rtl/imp_power_manager.sv ====
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// RQ1 - Idle sleep stops CPU, peripherals keep source
// RQ2 - Idle entry keeps status flags unchanged
// RQ3 - Internal and secondary oscillators keep running
// RQ4 - Idle exits only interrupt, watchdog, reset
// RQ5 - Fixed wake delay before execution resumes
// RQ6 - CPU wakes on Idle peripheral source
// RQ7 - Wake never alters idle or select bits
// RQ8 - Watchdog timeout in low power wakes
// RQ9 - Software sets select before primary idle
// RQ10 - Primary idle keeps primary clock, flag
// RQ11 - Secondary switch stops primary, sets flags
// RQ12 - Secondary wake keeps secondary oscillator running
// RQ13 - Secondary idle ignored if oscillator disabled
// RQ14 - Peripheral clocks wait for secondary start
// RQ15 - Internal switch stops primary, clears flag
// RQ16 - Internal oscillator stays for watchdog, monitor
// RQ17 - Enabled interrupt flag starts exit
// RQ18 - Branch to vector only when enabled
// RQ19 - Watchdog timeout while running resets
// RQ20 - Watchdog cleared by sleep, clear, loss
// RQ21 - Reset exit runs from internal oscillator
// RQ22 - Select decode 11 internal, 01 secondary
// RQ23 - Flags mirror which source clocks device
// RQ24 - Sleep with idle clear stops all
// RQ25 - Wake delay counter gates CPU enable
module imp_power_manager
    import imp_pkg::*;
#(
    parameter int WAKE_CYCLES = IMP_WAKE_CYCLES,
    parameter int WDT_WIDTH   = IMP_WDT_WIDTH
) (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [7:0]  reg_rdata,
    input  wire logic        sleep_instr,
    input  wire logic        wdt_clear_instr,
    input  wire logic [7:0]  irq_flags,
    input  wire logic        sec_osc_ready,
    input  wire logic        clk_src_lost,
    input  wire logic [WDT_WIDTH-1:0] wdt_limit,
    output var  logic        cpu_clk_en,
    output var  logic        periph_clk_en,
    output var  logic        pri_osc_en,
    output var  logic        sec_osc_run,
    output var  logic        int_osc_run,
    output var  logic [1:0]  cpu_src,
    output var  logic        cpu_resume,
    output var  logic        branch_vector,
    output var  logic        wdt_reset,
    output var  logic        primary_clock_active_flag,
    output var  logic        secondary_clock_active_flag
);

    typedef struct packed {
        imp_mode_t              mode;
        logic                   idle_on_sleep;
        logic [1:0]             sys_clock_select;
        logic                   secondary_osc_enable;
        logic                   wdt_enable;
        logic                   fscm_enable;
        logic [7:0]             irq_control_reg;
        logic [7:0]             periph_irq_enable_regs;
        logic                   pri_flag;
        logic                   sec_flag;
        logic [1:0]             src;
        logic [15:0]            wake_cnt;
        logic                   wake_irq;
        logic [WDT_WIDTH-1:0]   wdt_cnt;
        logic [7:0]             rdata;
        imp_clk_t               clk;
        logic                   resume;
        logic                   branch;
        logic                   wdt_rst;
    } imp_state_t;

    logic [2:0]  ready_sync_r;
    logic [2:0]  lost_sync_r;
    logic        ready_q_r;
    logic        lost_q_r;
    logic [1:0]  rst_sync_r;
    logic        rst_n;
    imp_state_t  st_r;
    imp_state_t  st_nxt;
    logic        irq_wake;
    logic        wdt_timeout;

    // Reset release through two flip-flops.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Asynchronous oscillator status pins: a change counts once stages two and three agree.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ready_sync_r <= 3'h0;
            lost_sync_r  <= 3'h0;
            ready_q_r    <= 1'b0;
            lost_q_r     <= 1'b0;
        end else begin
            ready_sync_r <= {ready_sync_r[1:0], sec_osc_ready};
            lost_sync_r  <= {lost_sync_r[1:0], clk_src_lost};
            if (ready_sync_r[1] == ready_sync_r[2]) begin
                ready_q_r <= ready_sync_r[2];
            end
            if (lost_sync_r[1] == lost_sync_r[2]) begin
                lost_q_r <= lost_sync_r[2];
            end
        end
    end

    // Only enabled sources wake; bit 7 of the interrupt control register is the global enable.
    assign irq_wake = |(irq_flags & {1'b0, st_r.irq_control_reg[6:0]})
                      | |(irq_flags & st_r.periph_irq_enable_regs); // RQ17
    assign wdt_timeout = st_r.wdt_enable && (st_r.wdt_cnt >= wdt_limit);

    always_comb begin
        st_nxt        = st_r;
        st_nxt.resume = 1'b0;
        st_nxt.wdt_rst = 1'b0;
        st_nxt.branch = 1'b0;
        st_nxt.rdata  = 8'h00;

        // Register port; the power manager never writes these on wake.
        if (reg_wr) begin // RQ7
            case (reg_addr)
                IMP_OFS_CTRL: begin
                    st_nxt.idle_on_sleep        = reg_wdata[IMP_CTRL_IDLE_BIT];
                    st_nxt.sys_clock_select     = reg_wdata[IMP_CTRL_SEL_LSB +: 2];
                    st_nxt.secondary_osc_enable = reg_wdata[IMP_CTRL_T1EN_BIT];
                    st_nxt.wdt_enable           = reg_wdata[IMP_CTRL_WDTE_BIT];
                    st_nxt.fscm_enable          = reg_wdata[IMP_CTRL_FSCM_BIT];
                end
                IMP_OFS_IRQCTL: st_nxt.irq_control_reg        = reg_wdata;
                IMP_OFS_PIE:    st_nxt.periph_irq_enable_regs = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                IMP_OFS_CTRL: st_nxt.rdata = {st_r.idle_on_sleep, 2'h0, st_r.fscm_enable,
                                              st_r.wdt_enable, st_r.secondary_osc_enable,
                                              st_r.sys_clock_select};
                IMP_OFS_STATUS: st_nxt.rdata = {4'h0, st_r.pri_flag, 1'b0,
                                                st_r.sec_flag, st_r.clk.cpu_clk_en};
                IMP_OFS_IRQCTL: st_nxt.rdata = st_r.irq_control_reg;
                IMP_OFS_PIE:    st_nxt.rdata = st_r.periph_irq_enable_regs;
                default:        st_nxt.rdata = 8'h00;
            endcase
        end

        // Watchdog counter.
        if (st_r.wdt_enable) begin
            st_nxt.wdt_cnt = st_r.wdt_cnt + 1'b1;
        end
        if (sleep_instr || wdt_clear_instr || (st_r.fscm_enable && lost_q_r)) begin
            st_nxt.wdt_cnt = '0; // RQ20
        end

        case (st_r.mode)
            IMP_RUN: begin
                // Run mode follows the select bits.
                st_nxt.src = (st_r.sys_clock_select == IMP_SEL_PRIMARY)   ? IMP_SEL_PRIMARY :
                             (st_r.sys_clock_select == IMP_SEL_SECONDARY) ? IMP_SEL_SECONDARY :
                             IMP_SEL_INTERNAL; // RQ22
                if (wdt_timeout) begin
                    st_nxt.wdt_rst = 1'b1; // RQ19
                    st_nxt.wdt_cnt = '0;
                end else if (sleep_instr) begin
                    if (!st_r.idle_on_sleep) begin
                        st_nxt.mode           = IMP_SLEEP; // RQ24
                        st_nxt.clk.cpu_clk_en = 1'b0;
                        st_nxt.clk.periph_clk_en = 1'b0;
                        st_nxt.pri_flag       = 1'b0;
                        st_nxt.sec_flag       = 1'b0;
                    end else if (st_r.sys_clock_select == IMP_SEL_SECONDARY
                                 && !st_r.secondary_osc_enable) begin
                        st_nxt.mode = IMP_RUN; // RQ13
                    end else begin
                        // Flags only change if the source really switches.
                        st_nxt.clk.cpu_clk_en = 1'b0; // RQ1 RQ2
                        if (st_nxt.src == IMP_SEL_SECONDARY && !ready_q_r) begin
                            st_nxt.mode = IMP_WAIT_OSC; // RQ14
                            st_nxt.clk.periph_clk_en = 1'b0;
                        end else begin
                            st_nxt.mode = IMP_IDLE;
                        end
                    end
                end
            end
            IMP_WAIT_OSC: begin
                if (ready_q_r) begin
                    st_nxt.mode = IMP_IDLE; // RQ14
                    st_nxt.clk.periph_clk_en = 1'b1;
                end else if (irq_wake || wdt_timeout) begin
                    st_nxt.mode = IMP_IDLE;
                end
            end
            IMP_IDLE, IMP_SLEEP: begin
                // Only interrupt or watchdog time-out leave; reset is the async path.
                if (irq_wake || wdt_timeout) begin // RQ4 RQ8
                    st_nxt.mode     = IMP_WAKE;
                    st_nxt.wake_cnt = 16'(WAKE_CYCLES); // RQ25
                    st_nxt.wake_irq = irq_wake && !wdt_timeout;
                    st_nxt.wdt_cnt  = '0;
                    st_nxt.clk.periph_clk_en = 1'b1;
                    if (st_r.mode == IMP_SLEEP) begin
                        st_nxt.src = (st_r.sys_clock_select == IMP_SEL_PRIMARY)   ? IMP_SEL_PRIMARY :
                                     (st_r.sys_clock_select == IMP_SEL_SECONDARY) ? IMP_SEL_SECONDARY :
                                     IMP_SEL_INTERNAL; // RQ8
                    end
                end
            end
            IMP_WAKE: begin
                // The CPU source stays that of the idle mode.
                if (st_r.wake_cnt > 16'h0001) begin
                    st_nxt.wake_cnt = st_r.wake_cnt - 16'h0001; // RQ5
                end else begin
                    st_nxt.mode           = IMP_RUN;
                    st_nxt.wake_cnt       = 16'h0000;
                    st_nxt.clk.cpu_clk_en = 1'b1; // RQ5 RQ6 RQ25
                    st_nxt.resume         = 1'b1;
                    st_nxt.branch = st_r.wake_irq
                                    && st_r.irq_control_reg[IMP_IRQ_GIE_BIT]; // RQ18
                end
            end
            default: st_nxt.mode = IMP_RUN;
        endcase

        // Status flags mirror the source that clocks the device.
        if (st_nxt.mode != IMP_SLEEP && st_nxt.src != st_r.src) begin
            st_nxt.pri_flag = (st_nxt.src == IMP_SEL_PRIMARY);   // RQ11 RQ15 RQ23
            st_nxt.sec_flag = (st_nxt.src == IMP_SEL_SECONDARY); // RQ11
        end
        if (st_r.mode == IMP_SLEEP && st_nxt.mode == IMP_WAKE) begin
            st_nxt.pri_flag = (st_nxt.src == IMP_SEL_PRIMARY);
            st_nxt.sec_flag = (st_nxt.src == IMP_SEL_SECONDARY);
        end

        // Oscillator enables; primary idle keeps the primary running.
        st_nxt.clk.pri_osc_en = (st_nxt.mode != IMP_SLEEP)
                                && (st_nxt.src == IMP_SEL_PRIMARY); // RQ10 RQ11 RQ15
        st_nxt.clk.sec_osc_run = st_nxt.secondary_osc_enable; // RQ3 RQ12
        st_nxt.clk.int_osc_run = st_nxt.wdt_enable || st_nxt.fscm_enable
                                 || ((st_nxt.mode != IMP_SLEEP)
                                     && (st_nxt.src == IMP_SEL_INTERNAL)); // RQ3 RQ16
        st_nxt.clk.cpu_src = st_nxt.src; // RQ6 RQ12 RQ16
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            // Reset exits run from the internal oscillator with the select bits at reset.
            st_r                        <= '0;
            st_r.mode                   <= IMP_RUN;
            st_r.sys_clock_select       <= IMP_SEL_RST;
            st_r.irq_control_reg        <= IMP_IRQ_RST;
            st_r.periph_irq_enable_regs <= IMP_PIE_RST;
            st_r.src                    <= IMP_SEL_INTERNAL; // RQ21
            st_r.clk.cpu_clk_en         <= 1'b1;
            st_r.clk.periph_clk_en      <= 1'b1;
            st_r.clk.int_osc_run        <= 1'b1;
            st_r.clk.cpu_src            <= IMP_SEL_INTERNAL; // RQ21
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata                   = st_r.rdata;
    assign cpu_clk_en                  = st_r.clk.cpu_clk_en;
    assign periph_clk_en               = st_r.clk.periph_clk_en;
    assign pri_osc_en                  = st_r.clk.pri_osc_en;
    assign sec_osc_run                 = st_r.clk.sec_osc_run;
    assign int_osc_run                 = st_r.clk.int_osc_run;
    assign cpu_src                     = st_r.clk.cpu_src;
    assign cpu_resume                  = st_r.resume;
    assign branch_vector               = st_r.branch;
    assign wdt_reset                   = st_r.wdt_rst;
    assign primary_clock_active_flag   = st_r.pri_flag;
    assign secondary_clock_active_flag = st_r.sec_flag;

endmodule : imp_power_manager

`default_nettype wire

// ==== test/imp_power_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module imp_power_monitor
    import imp_pkg::*;
#(
    parameter int WAKE_CYCLES = IMP_WAKE_CYCLES
) (
    input wire logic       mclk,
    input wire logic       arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       sleep_instr,
    input wire logic [7:0] irq_flags,
    input wire logic       cpu_clk_en,
    input wire logic       periph_clk_en,
    input wire logic       pri_osc_en,
    input wire logic [1:0] cpu_src,
    input wire logic       cpu_resume,
    input wire logic       branch_vector,
    input wire logic       wdt_reset,
    input wire logic       primary_clock_active_flag,
    input wire logic       secondary_clock_active_flag
);
    logic [7:0] ctl_r;
    logic [7:0] irq_r;
    logic [7:0] pie_r;
    logic [1:0] ent_r;
    logic       ent_idle_r;
    logic       pend_r;
    logic [7:0] cnt_r;
    logic       pend;
    logic       take;
    logic       idle;
    logic [1:0] sel;
    assign pend = |(irq_flags & (pie_r | {1'b0, irq_r[6:0]}));
    assign take = sleep_instr && cpu_clk_en;
    assign idle = ctl_r[IMP_CTRL_IDLE_BIT];
    assign sel  = ctl_r[1:0];
    // Shadow of the setup written by software, since the block hides its registers.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_r <= {6'h00, IMP_SEL_RST};
            irq_r <= IMP_IRQ_RST;
            pie_r <= IMP_PIE_RST;
        end else if (reg_wr) begin
            if (reg_addr == IMP_OFS_CTRL) ctl_r <= reg_wdata;
            if (reg_addr == IMP_OFS_IRQCTL) irq_r <= reg_wdata;
            if (reg_addr == IMP_OFS_PIE) pie_r <= reg_wdata;
        end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ent_r      <= IMP_SEL_INTERNAL;
            ent_idle_r <= 1'b0;
            pend_r     <= 1'b0;
            cnt_r      <= 8'h00;
        end else begin
            if (take) begin
                ent_r      <= sel;
                ent_idle_r <= idle;
            end
            pend_r <= !cpu_clk_en && (pend_r || pend);
            cnt_r  <= (!cpu_clk_en && (pend_r || pend)) ? cnt_r + 8'h01 : 8'h00;
        end
    end
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!arst_n);
    chk_idle_cpu_gate: assert property (take && idle && sel != IMP_SEL_SECONDARY
        |=> !cpu_clk_en && periph_clk_en) else $error("idle entry gating wrong");
    chk_idle_flags_hold: assert property (take && idle && cpu_src == sel
        |=> ($stable(primary_clock_active_flag) && $stable(secondary_clock_active_flag)) [*3])
        else $error("status flags moved on idle entry");
    chk_sleep_all_off: assert property (take && !idle
        |=> !cpu_clk_en && !periph_clk_en) else $error("sleep left a clock running");
    chk_sec_refused: assert property (take && idle && sel == IMP_SEL_SECONDARY
        && !ctl_r[IMP_CTRL_T1EN_BIT] |=> cpu_clk_en [*4]) else $error("refused idle entered");
    chk_wake_cause: assert property ($rose(cpu_clk_en) && !ctl_r[IMP_CTRL_WDTE_BIT]
        |-> pend_r) else $error("cpu clock restarted without a wake event");
    chk_wake_delay: assert property ($rose(cpu_clk_en) && pend_r
        |-> cnt_r >= WAKE_CYCLES - 1 && cnt_r <= WAKE_CYCLES + 3) else $error("wake delay off");
    chk_resume_edge: assert property (cpu_resume |-> $rose(cpu_clk_en))
        else $error("resume not with cpu clock start");
    chk_vector_gie: assert property (cpu_resume && pend_r |-> branch_vector == irq_r[7])
        else $error("branch decision wrong");
    chk_idle_src: assert property ($rose(cpu_clk_en) && ent_idle_r |-> cpu_src == ent_r)
        else $error("cpu woke on another source");
    chk_wdt_run_only: assert property (wdt_reset |-> cpu_clk_en && $past(cpu_clk_en))
        else $error("watchdog reset outside run mode");
    chk_flag_excl: assert property (primary_clock_active_flag
        |-> pri_osc_en && !secondary_clock_active_flag) else $error("flags disagree");
endmodule : imp_power_monitor
bind imp_power_manager imp_power_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) mon_u (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .sleep_instr(sleep_instr), .irq_flags(irq_flags),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .pri_osc_en(pri_osc_en),
    .cpu_src(cpu_src), .cpu_resume(cpu_resume), .branch_vector(branch_vector),
    .wdt_reset(wdt_reset), .primary_clock_active_flag(primary_clock_active_flag),
    .secondary_clock_active_flag(secondary_clock_active_flag));
`default_nettype wire

// ==== test/imp_far_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module imp_far_model #(
    parameter int OSC_START = 12
) (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic [7:0] fire,
    input  wire logic       sec_osc_run,
    input  wire logic       cpu_resume,
    output logic [7:0]      irq_flags,
    output logic            sec_osc_ready
);
    int osc_cnt;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_flags <= 8'h00;
            osc_cnt   <= 0;
        end else begin
            // A handler clears flags once code runs; a flag left up would rewake at once.
            irq_flags <= cpu_resume ? fire : (irq_flags | fire);
            osc_cnt   <= !sec_osc_run ? 0 : (osc_cnt < OSC_START ? osc_cnt + 1 : osc_cnt);
        end
    end
    // The crystal needs time to start, so ready lags the enable.
    assign sec_osc_ready = sec_osc_run && osc_cnt == OSC_START;
endmodule : imp_far_model
`default_nettype wire

// ==== test/idle_mode_power_manager_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module idle_mode_power_manager_tb
    import imp_pkg::*;
;
    localparam int WC  = 4;
    localparam int LIM = 20;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        sleep_instr = 1'b0;
    logic        wdt_clear_instr = 1'b0;
    logic [7:0]  fire = 8'h00;
    logic [15:0] wdt_limit = 16'h0014;
    logic        lost = 1'b0;
    logic [7:0]  reg_rdata, irq_flags, rdv, got, ctl_v;
    logic [1:0]  cpu_src;
    logic        cpu_clk_en, periph_clk_en, pri_osc_en, sec_osc_run, int_osc_run;
    logic        cpu_resume, branch_vector, wdt_reset, pflag, sflag, sec_osc_ready;
    int          n_fail = 0, num_checks = 0, cyc = 0, hits = 0;

    always #2.5 mclk = ~mclk;

    imp_power_manager #(.WAKE_CYCLES(WC), .WDT_WIDTH(16)) dut_u (
        .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_instr(sleep_instr),
        .wdt_clear_instr(wdt_clear_instr), .irq_flags(irq_flags),
        .sec_osc_ready(sec_osc_ready), .clk_src_lost(lost), .wdt_limit(wdt_limit),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .pri_osc_en(pri_osc_en),
        .sec_osc_run(sec_osc_run), .int_osc_run(int_osc_run), .cpu_src(cpu_src),
        .cpu_resume(cpu_resume), .branch_vector(branch_vector), .wdt_reset(wdt_reset),
        .primary_clock_active_flag(pflag), .secondary_clock_active_flag(sflag));
    imp_far_model #(.OSC_START(12)) far_u (.mclk(mclk), .arst_n(arst_n), .fire(fire),
        .sec_osc_run(sec_osc_run), .cpu_resume(cpu_resume), .irq_flags(irq_flags),
        .sec_osc_ready(sec_osc_ready));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    task automatic chk8(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk8
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata;
    endtask : rd
    task automatic do_sleep;
        @(posedge mclk);
        sleep_instr <= 1'b1;
        @(posedge mclk);
        sleep_instr <= 1'b0;
        tick(1);
    endtask : do_sleep
    task automatic do_fire(input logic [7:0] m);
        @(posedge mclk);
        fire <= m;
        @(posedge mclk);
        fire <= 8'h00;
    endtask : do_fire
    // The resume pulse lasts one cycle, so every cycle of the window is looked at.
    task automatic wait_res(input int max);
        got = 8'h00;
        repeat (max) begin
            tick(1);
            if (cpu_resume === 1'b1) got = {1'b1, branch_vector, 4'h0, cpu_src};
        end
    endtask : wait_res
    task automatic t_reset;
        @(posedge mclk);
        arst_n <= 1'b0;
        tick(3);
        arst_n <= 1'b1;
        // The reset state stands until the third edge, when run mode follows the select bits.
        tick(2);
        ctl_v = {6'h00, IMP_SEL_RST};
        chk8("reset outs", {cpu_clk_en, periph_clk_en, int_osc_run, pflag, sflag, 1'b0, cpu_src},
            8'hE3);
        rd(IMP_OFS_CTRL);
        chk8("ctrl", rdv, ctl_v);
        rd(4'hF);
        chk8("unmapped", rdv, 8'h00);
        rd(IMP_OFS_STATUS);
        chk8("status", rdv, 8'h09);
        $display("test reset done");
    endtask : t_reset
    task automatic t_idle(input logic [1:0] sel, input logic gie);
        wr(IMP_OFS_CTRL, ctl_v | 8'h80);
        ctl_v = 8'h84 | {6'h00, sel};
        wr(IMP_OFS_CTRL, ctl_v);
        wr(IMP_OFS_IRQCTL, {gie, 7'h00});
        wr(IMP_OFS_PIE, 8'h01);
        do_sleep;
        chk8("early", {6'h00, cpu_clk_en, periph_clk_en}, {7'h00, sel != 2'h1});
        do_fire(8'h02);
        tick(20);
        chk8("masked", {6'h00, cpu_clk_en, periph_clk_en}, 8'h01);
        do_fire(8'h01);
        wait_res(WC + 10);
        chk8("wake", got, {1'b1, gie, 4'h0, sel});
        chk8("flags", {6'h00, pflag, sflag}, {6'h00, sel == 2'h2, sel == 2'h1});
        chk8("osc", {6'h00, sec_osc_run, pri_osc_en}, {7'h01, sel == 2'h2});
        rd(IMP_OFS_CTRL);
        chk8("ctrl kept", rdv, ctl_v);
        rd(IMP_OFS_PIE);
        chk8("pie kept", rdv, 8'h01);
        $display("test idle %0d done", sel);
    endtask : t_idle
    task automatic t_refuse;
        ctl_v = 8'h81;
        wr(IMP_OFS_CTRL, ctl_v);
        do_sleep;
        tick(3);
        chk8("refused", {7'h00, cpu_clk_en}, 8'h01);
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_sleep;
        ctl_v = 8'h03;
        wr(IMP_OFS_CTRL, ctl_v);
        wr(IMP_OFS_IRQCTL, 8'h00);
        do_sleep;
        chk8("sleep clk", {6'h00, cpu_clk_en, periph_clk_en}, 8'h00);
        do_fire(8'h01);
        wait_res(WC + 10);
        chk8("sleep wake", got, {2'b10, 4'h0, IMP_SEL_INTERNAL});
        $display("test sleep done");
    endtask : t_sleep
    task automatic t_wdt;
        ctl_v = 8'h0B;
        wr(IMP_OFS_CTRL, ctl_v);
        hits = 0;
        repeat (5) begin
            tick(8);
            @(posedge mclk);
            wdt_clear_instr <= 1'b1;
            @(posedge mclk);
            wdt_clear_instr <= 1'b0;
        end
        chk8("wdt cleared", 8'(hits), 8'h00);
        tick(LIM + 10);
        chk8("wdt run", {7'h00, hits > 0}, 8'h01);
        wr(IMP_OFS_CTRL, 8'h1B);
        lost <= 1'b1;
        hits = 0;
        tick(LIM + 10);
        chk8("wdt lost", 8'(hits), 8'h00);
        lost <= 1'b0;
        ctl_v = 8'h8B;
        wr(IMP_OFS_CTRL, ctl_v);
        do_sleep;
        hits = 0;
        chk8("int osc", {7'h00, int_osc_run}, 8'h01);
        wait_res(LIM + WC + 15);
        chk8("wdt wake", got & 8'hBF, {2'b10, 4'h0, IMP_SEL_INTERNAL});
        chk8("no wdt reset", 8'(hits), 8'h00);
        ctl_v = 8'h03;
        wr(IMP_OFS_CTRL, ctl_v);
        $display("test watchdog done");
    endtask : t_wdt

    always @(posedge mclk) begin
        if (wdt_reset === 1'b1) hits++;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            give_verdict;
        end
    end
    initial begin
        t_reset;
        t_idle(IMP_SEL_SECONDARY, 1'b1);
        t_idle(IMP_SEL_INTERNAL, 1'b0);
        t_idle(IMP_SEL_PRIMARY, 1'b1);
        t_refuse;
        t_sleep;
        t_wdt;
        wr(IMP_OFS_CTRL, 8'h82);
        do_sleep;
        t_reset;
        give_verdict;
    end
endmodule : idle_mode_power_manager_tb
`default_nettype wire
